// *** rtl/sms_ctrl.sv ***
// serial master/slave controller with control, status and data registers
// Overview of operation
// - rate select divides peripheral clock 2..128 or 1
// - serial clock idles at polarity level
// - phase picks sampling and shifting clock edges
// - phase set samples returning, clear leaving
// - disabled interface drives serial clock high
// - master samples slave output; slave samples master output
// - bytes shift most significant bit first
// - data write starts master byte; read buffer
// - phase 0 slave presents top bit on select
// - phase 0 select released between bytes
// - phase 1 first edge starts each byte
// - select disable frees pin; slave phase 0 ignores
// - master sees select low sets mode fault
// - mode fault clears enable and master bits
// - mode fault cleared by status read, control write
// - data write while busy flags collision, discarded
// - collision flag never requests interrupt
// - collision cleared by status read, idle write
// - byte end sets done; status then data clears
// - done or fault, gated by both enables
// - master bit set means master; only master starts
// - slave needs master bit clear and loaded data
`timescale 1ns/100ps
`default_nettype none
module sms_ctrl (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// special function register port
	input wire logic [1:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// interrupt enables and request
	input wire logic serial_irq_enable,
	input wire logic global_irq_enable,
	output logic irq,
	// serial link
	sms_link_if.dev link
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic [7:0] sr;
		logic [7:0] rxbuf;
		logic done;
		logic write_collision_flag;
		logic mode_fault_flag;
		logic armed;
		logic busy;
		logic loaded;
		logic [3:0] h;
		logic [6:0] cnt;
		logic act;
		logic sck_q;
		logic dout;
	} sms_dev_s;
	sms_dev_s s_r;
	sms_dev_s s_nxt;

	// ----------------------------------------
	// decoded control fields
	// ----------------------------------------
	logic iface_enable;
	logic master_select;
	logic clock_polarity;
	logic clock_phase;
	logic select_input_disable;
	logic [2:0] rate;
	logic [7:0] div;
	logic sel;
	logic din;
	logic [1:0] edg;
	assign iface_enable = s_r.ctrl[sms_pkg::CTL_ENABLE];
	assign master_select = s_r.ctrl[sms_pkg::CTL_MASTER];
	assign clock_polarity = s_r.ctrl[sms_pkg::CTL_CLOCK_POLARITY];
	assign clock_phase = s_r.ctrl[sms_pkg::CTL_CLOCK_PHASE];
	assign select_input_disable = s_r.ctrl[sms_pkg::CTL_SS_DIS];
	assign rate = {s_r.ctrl[sms_pkg::CTL_RATE_HI], s_r.ctrl[sms_pkg::CTL_RATE_MID],
		s_r.ctrl[sms_pkg::CTL_RATE_LO]};
	assign div = sms_pkg::DIV_TBL[rate];
	assign sel = !link.ss_n || (select_input_disable && clock_phase);
	assign din = master_select ? link.miso : link.mosi;

	// status byte with reserved bits as zero
	function automatic logic [7:0] stat_byte(input logic d, input logic w, input logic m);
		logic [7:0] b;
		b = 8'h00;
		b[sms_pkg::STA_DONE] = d;
		b[sms_pkg::STA_WRITE_COLLISION_FLAG] = w;
		b[sms_pkg::STA_MODE_FAULT_FLAG] = m;
		return b;
	endfunction : stat_byte

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign sfr_rdata = s_r.rdata;
	assign irq = (s_r.done || s_r.mode_fault_flag) && serial_irq_enable && global_irq_enable;
	assign link.dev_sck_o = iface_enable ? (clock_polarity ^ s_r.act) : 1'b1;
	assign link.dev_sck_oe_n = !(master_select || !iface_enable);
	assign link.dev_mosi_o = s_r.dout;
	assign link.dev_mosi_oe_n = !(master_select && iface_enable);
	assign link.dev_miso_o = s_r.dout;
	assign link.dev_miso_oe_n = !(!master_select && iface_enable && sel && s_r.loaded);

	// next state: register access, shift engine, fault watch
	always_comb begin
		s_nxt = s_r;
		edg = 2'b00;
		s_nxt.sck_q = link.sck;
		// register reads and their side effects
		if (sfr_rd) begin
			case (sfr_addr)
				sms_pkg::REG_CTRL: s_nxt.rdata = s_r.ctrl;
				sms_pkg::REG_STAT: begin
					s_nxt.rdata = stat_byte(s_r.done, s_r.write_collision_flag, s_r.mode_fault_flag);
					s_nxt.armed = 1'b1;
				end
				sms_pkg::REG_DATA: begin
					s_nxt.rdata = s_r.rxbuf;
					if (s_r.armed) begin
						s_nxt.done = 1'b0;
						s_nxt.armed = 1'b0;
					end
				end
				default: s_nxt.rdata = 8'h00;
			endcase
		end
		// register writes
		if (sfr_wr && sfr_addr == sms_pkg::REG_CTRL) begin
			s_nxt.ctrl = sfr_wdata;
			if (s_r.armed)
				s_nxt.mode_fault_flag = 1'b0;
		end
		if (sfr_wr && sfr_addr == sms_pkg::REG_DATA) begin
			if (s_r.armed) begin
				s_nxt.done = 1'b0;
				s_nxt.armed = 1'b0;
			end
			if (s_r.busy || s_r.h != 4'h0) begin
				s_nxt.write_collision_flag = 1'b1;
			end else begin
				if (s_r.armed)
					s_nxt.write_collision_flag = 1'b0;
				s_nxt.sr = sfr_wdata;
				s_nxt.dout = sfr_wdata[7];
				if (master_select && iface_enable) begin
					s_nxt.busy = 1'b1;
					s_nxt.cnt = 7'h00;
				end else if (!master_select) begin
					s_nxt.loaded = 1'b1;
				end
			end
		end
		// master: bit rate generator produces the clock edges
		if (s_r.busy && master_select) begin
			if (div == 8'h01) begin
				edg = 2'b11;
			end else if (s_r.cnt == 7'(div[7:1] - 8'h01)) begin
				s_nxt.cnt = 7'h00;
				edg[s_r.h[0]] = 1'b1;
				s_nxt.act = !s_r.act;
			end else begin
				s_nxt.cnt = s_r.cnt + 7'h01;
			end
		end
		// slave: edges of the external master clock
		if (iface_enable && !master_select && s_r.loaded) begin
			if (!sel) begin
				s_nxt.h = 4'h0;
			end else if (link.sck != s_r.sck_q) begin
				edg[0] = (link.sck != clock_polarity);
				edg[1] = !edg[0];
			end
		end
		// edge actions, leading edge first
		for (int e = 0; e < 2; e++) begin
			if (edg[e]) begin
				if ((e == 1) == clock_phase)
					s_nxt.sr = {s_nxt.sr[6:0], din};
				else
					s_nxt.dout = s_nxt.sr[7];
				if (s_nxt.h == sms_pkg::LAST_EDGE) begin
					s_nxt.h = 4'h0;
					s_nxt.rxbuf = s_nxt.sr;
					s_nxt.done = 1'b1;
					s_nxt.busy = 1'b0;
					s_nxt.loaded = 1'b0;
					s_nxt.act = 1'b0;
				end else begin
					s_nxt.h = s_nxt.h + 4'h1;
				end
			end
		end
		// foreign master pulled select low
		if (master_select && iface_enable && !select_input_disable && link.ss_n == 1'b0) begin
			s_nxt.mode_fault_flag = 1'b1;
			s_nxt.ctrl[sms_pkg::CTL_ENABLE] = 1'b0;
			s_nxt.ctrl[sms_pkg::CTL_MASTER] = 1'b0;
			// a status read made before the fault must not count towards clearing it
			s_nxt.armed = 1'b0;
			s_nxt.busy = 1'b0;
			s_nxt.h = 4'h0;
			s_nxt.act = 1'b0;
		end
		if (!iface_enable) begin
			s_nxt.busy = 1'b0;
			s_nxt.h = 4'h0;
			s_nxt.act = 1'b0;
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_r <= '0;
			s_r.ctrl <= sms_pkg::CTRL_RESET;
		end else begin
			s_r <= s_nxt;
		end
	end
endmodule : sms_ctrl
`default_nettype wire

// *** rtl/sms_pkg.sv ***
// shared constants of the serial master/slave controller and its link partner
package sms_pkg;
	// device register select codes on the special function port
	localparam logic [1:0] REG_CTRL = 2'h0;
	localparam logic [1:0] REG_STAT = 2'h1;
	localparam logic [1:0] REG_DATA = 2'h2;
	// control register layout and reset
	localparam int CTL_RATE_HI = 7;
	localparam int CTL_ENABLE = 6;
	localparam int CTL_SS_DIS = 5;
	localparam int CTL_MASTER = 4;
	localparam int CTL_CLOCK_POLARITY = 3;
	localparam int CTL_CLOCK_PHASE = 2;
	localparam int CTL_RATE_MID = 1;
	localparam int CTL_RATE_LO = 0;
	localparam logic [7:0] CTRL_RESET = 8'h14;
	// status register layout
	localparam int STA_DONE = 7;
	localparam int STA_WRITE_COLLISION_FLAG = 6;
	localparam int STA_MODE_FAULT_FLAG = 4;
	// peripheral clock divider per rate select code
	localparam logic [7:0] DIV_TBL [8] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80, 8'h01};
	// index of the last of the 16 edges in one byte, two per bit
	localparam logic [3:0] LAST_EDGE = 4'hF;
	// partner register byte offsets over the lite bus
	localparam logic [3:0] PTN_CFG = 4'h0;
	localparam logic [3:0] PTN_TX = 4'h4;
	localparam logic [3:0] PTN_RX = 4'h8;
	localparam int PTN_CFG_CLOCK_PHASE = 0;
	localparam int PTN_CFG_CLOCK_POLARITY = 1;
	localparam int PTN_RX_DONE = 8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
endpackage : sms_pkg

// *** rtl/sms_link_if.sv ***
// serial link wires joining the controller and its partner
`timescale 1ns/100ps
`default_nettype none
interface sms_link_if;
	// controller pin drivers, enables active low
	logic dev_sck_o;
	logic dev_sck_oe_n;
	logic dev_mosi_o;
	logic dev_mosi_oe_n;
	logic dev_miso_o;
	logic dev_miso_oe_n;
	// partner pin drivers
	logic ptn_miso_o;
	logic ptn_miso_oe_n;
	// select line, driven by the bench as a port pin or a foreign master
	logic ss_n;
	// resolved wire levels, undriven lines pulled high
	logic sck;
	logic mosi;
	logic miso;
	assign sck = dev_sck_oe_n ? 1'b1 : dev_sck_o;
	assign mosi = dev_mosi_oe_n ? 1'b1 : dev_mosi_o;
	assign miso = !dev_miso_oe_n ? dev_miso_o : (!ptn_miso_oe_n ? ptn_miso_o : 1'b1);
	modport dev (output dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n,
		dev_miso_o, dev_miso_oe_n, input sck, mosi, miso, ss_n);
	modport ptn (output ptn_miso_o, ptn_miso_oe_n, input sck, mosi, ss_n);
endinterface : sms_link_if
`default_nettype wire

// *** rtl/sms_partner.sv ***
// link partner: serial slave peripheral steered over an AXI4-Lite port
`timescale 1ns/100ps
`default_nettype none
module sms_partner #(
	parameter int ADDR_W = 4
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// lite bus write side
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// lite bus read side
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// serial link
	sms_link_if.ptn link
);
	if (ADDR_W < 4) begin : g_chk
		$error("sms_partner: ADDR_W below 4");
	end

	typedef struct packed {
		logic aw_ok;
		logic w_ok;
		logic [3:0] waddr;
		logic [31:0] wdata;
		logic bvalid;
		logic rvalid;
		logic [31:0] rdata;
		logic clock_phase;
		logic clock_polarity;
		logic [7:0] tx;
		logic [7:0] sr;
		logic [7:0] rx;
		logic done;
		logic [3:0] h;
		logic sck_q;
		logic dout;
	} sms_ptn_s;
	sms_ptn_s s_r;
	sms_ptn_s s_nxt;
	logic [1:0] edg;

	// handshake outputs
	assign s_axi_awready = !s_r.aw_ok && !s_r.bvalid;
	assign s_axi_wready = !s_r.w_ok && !s_r.bvalid;
	assign s_axi_arready = !s_r.rvalid;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_rvalid = s_r.rvalid;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_bresp = sms_pkg::RESP_OKAY;
	assign s_axi_rresp = sms_pkg::RESP_OKAY;
	assign link.ptn_miso_o = s_r.dout;
	assign link.ptn_miso_oe_n = link.ss_n;

	// next state: bus slave and serial slave engine
	always_comb begin
		s_nxt = s_r;
		edg = 2'b00;
		if (s_axi_awvalid && s_axi_awready) begin
			s_nxt.aw_ok = 1'b1;
			s_nxt.waddr = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_nxt.w_ok = 1'b1;
			s_nxt.wdata = s_axi_wdata;
		end
		if (s_r.bvalid && s_axi_bready)
			s_nxt.bvalid = 1'b0;
		if (s_r.aw_ok && s_r.w_ok) begin
			s_nxt.aw_ok = 1'b0;
			s_nxt.w_ok = 1'b0;
			s_nxt.bvalid = 1'b1;
			if (s_r.waddr == sms_pkg::PTN_CFG) begin
				s_nxt.clock_phase = s_r.wdata[sms_pkg::PTN_CFG_CLOCK_PHASE];
				s_nxt.clock_polarity = s_r.wdata[sms_pkg::PTN_CFG_CLOCK_POLARITY];
			end else if (s_r.waddr == sms_pkg::PTN_TX) begin
				s_nxt.tx = s_r.wdata[7:0];
			end
		end
		if (s_r.rvalid && s_axi_rready)
			s_nxt.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready) begin
			s_nxt.rvalid = 1'b1;
			case (s_axi_araddr[3:0])
				sms_pkg::PTN_CFG: s_nxt.rdata = {30'h0, s_r.clock_polarity, s_r.clock_phase};
				sms_pkg::PTN_TX: s_nxt.rdata = {24'h0, s_r.tx};
				sms_pkg::PTN_RX: begin
					s_nxt.rdata = {23'h0, s_r.done, s_r.rx};
					s_nxt.done = 1'b0; // read clears; a byte ending now sets it again below
				end
				default: s_nxt.rdata = 32'h0;
			endcase
		end
		// serial slave: edges seen on the master clock
		s_nxt.sck_q = link.sck;
		if (link.ss_n) begin
			s_nxt.h = 4'h0;
			s_nxt.sr = s_r.tx;
			s_nxt.dout = s_r.tx[7];
		end else if (link.sck != s_r.sck_q) begin
			edg[0] = (link.sck != s_r.clock_polarity);
			edg[1] = !edg[0];
		end else if (s_r.h == 4'h0 && !s_r.clock_phase) begin
			s_nxt.sr = s_r.tx;
			s_nxt.dout = s_r.tx[7];
		end
		for (int e = 0; e < 2; e++) begin
			if (edg[e]) begin
				if ((e == 1) == s_nxt.clock_phase)
					s_nxt.sr = {s_nxt.sr[6:0], link.mosi};
				else
					s_nxt.dout = s_nxt.sr[7];
				if (s_nxt.h == sms_pkg::LAST_EDGE) begin
					s_nxt.h = 4'h0;
					s_nxt.rx = s_nxt.sr;
					s_nxt.done = 1'b1;
					s_nxt.sr = s_r.tx;
				end else begin
					s_nxt.h = s_nxt.h + 4'h1;
				end
			end
		end
	end

	// state register
	always_ff @(posedge aclk) begin
		if (!aresetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end
endmodule : sms_partner
`default_nettype wire

// *** tb/sms_monitor.sv ***
// link and interrupt assertions for the controller and partner pair
`timescale 1ns/100ps
`default_nettype none
module sms_monitor (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// link signals
	input wire logic dev_sck_o,
	input wire logic dev_sck_oe_n,
	input wire logic dev_mosi_oe_n,
	input wire logic dev_miso_oe_n,
	input wire logic ptn_miso_oe_n,
	input wire logic ss_n,
	// interrupt
	input wire logic irq,
	input wire logic serial_irq_enable,
	input wire logic global_irq_enable
);
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// leaving reset the interface is disabled, so the clock pin is driven high
	property p_rst_sck; !$past(aresetn) |-> !dev_sck_oe_n && dev_sck_o; endproperty
	a_rst_sck: assert property (p_rst_sck) else $error("sck not high after reset");
	// leaving reset no data line is driven and no request stands
	property p_rst_quiet; !$past(aresetn) |-> dev_mosi_oe_n && dev_miso_oe_n && !irq; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("active after reset");
	// request only while both enables are high
	property p_irq_gate; irq |-> serial_irq_enable && global_irq_enable; endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
	// dropping the peripheral enable drops the request at once
	property p_irq_fell; $fell(serial_irq_enable) |-> !irq; endproperty
	a_irq_fell: assert property (p_irq_fell) else $error("irq kept after mask");
	// master and slave output are never driven together
	property p_one_role; !dev_mosi_oe_n |-> dev_miso_oe_n; endproperty
	a_one_role: assert property (p_one_role) else $error("both data outputs driven");
	// a driving slave leaves the clock to the other master
	property p_slave_no_sck; !dev_miso_oe_n |-> dev_sck_oe_n; endproperty
	a_slave_no_sck: assert property (p_slave_no_sck) else $error("slave drives sck");
	// partner output only while selected
	property p_ptn_sel; ss_n |-> ptn_miso_oe_n; endproperty
	a_ptn_sel: assert property (p_ptn_sel) else $error("partner drives unselected");
	// partner presents its first bit as soon as it is selected
	property p_ptn_fell; $fell(ss_n) |-> !ptn_miso_oe_n; endproperty
	a_ptn_fell: assert property (p_ptn_fell) else $error("partner late on select");
endmodule : sms_monitor
`default_nettype wire

// *** tb/sms_ctrl_tb.sv ***
// self-checking bench: controller as master against the link partner, then slave output checks alone
`timescale 1ns/100ps
`default_nettype none
module sms_ctrl_tb;
	// ---------------------------------------------------------------
	// signals and instances
	// ---------------------------------------------------------------
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic [1:0] sfr_addr = 2'h0;
	logic sfr_wr = 1'h0;
	logic sfr_rd = 1'h0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic serial_irq_enable = 1'h1;
	logic global_irq_enable = 1'h1;
	logic irq;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	int n_mismatch = 0, n_compared = 0, n_sck = 0, cyc = 0;
	sms_link_if link ();
	sms_ctrl i_sms_ctrl (.aclk(aclk), .aresetn(aresetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq(irq),
		.serial_irq_enable(serial_irq_enable), .global_irq_enable(global_irq_enable),
		.link(link.dev));
	sms_partner i_sms_partner (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.ptn));
	sms_monitor i_sms_monitor (.aclk(aclk), .aresetn(aresetn), .dev_sck_o(link.dev_sck_o),
		.dev_sck_oe_n(link.dev_sck_oe_n), .dev_mosi_oe_n(link.dev_mosi_oe_n),
		.dev_miso_oe_n(link.dev_miso_oe_n), .ptn_miso_oe_n(link.ptn_miso_oe_n), .ss_n(link.ss_n),
		.irq(irq), .serial_irq_enable(serial_irq_enable), .global_irq_enable(global_irq_enable));
	// clock, cycle count and serial clock edge count
	always #5 aclk = ~aclk;
	always @(posedge aclk) cyc <= cyc + 1;
	always @(link.sck) n_sck++;
	// ---------------------------------------------------------------
	// access and check tasks
	// ---------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic sfr_w(input logic [1:0] a, input logic [7:0] d);
		@(posedge aclk);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= 1'h1;
		@(posedge aclk);
		sfr_wr <= 1'h0;
	endtask : sfr_w
	task automatic sfr_r(input logic [1:0] a, output logic [7:0] d);
		@(posedge aclk);
		sfr_addr <= a;
		sfr_rd <= 1'h1;
		@(posedge aclk);
		sfr_rd <= 1'h0;
		@(posedge aclk);
		d = sfr_rdata;
	endtask : sfr_r
	task automatic rchk(input string w, input logic [1:0] a, input logic [7:0] e);
		logic [7:0] d;
		sfr_r(a, d);
		chk(w, d, e);
	endtask : rchk
	// lite writes offer address and data together, each released when taken
	task automatic axi_w(input logic [3:0] a, input logic [31:0] d);
		logic done;
		done = 1'h0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!done) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'h0;
			if (wvalid && wready) wvalid <= 1'h0;
			if (bvalid && bready) begin
				bready <= 1'h0;
				done = 1'h1;
			end
		end
	endtask : axi_w
	task automatic axi_r(input logic [3:0] a, output logic [31:0] d);
		logic done;
		done = 1'h0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		while (!done) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'h0;
			if (rvalid && rready) begin
				d = rdata;
				rready <= 1'h0;
				done = 1'h1;
			end
		end
	endtask : axi_r
	task automatic stop_test();
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	// watchdog against a hung handshake
	initial begin
		repeat (30000) @(posedge aclk);
		n_mismatch++;
		stop_test();
	end
	// ---------------------------------------------------------------
	// test sequence
	// ---------------------------------------------------------------
	initial begin
		logic [7:0] ctl, dtx, ptx, d8;
		logic [31:0] r;
		int dv, t0;
		link.ss_n <= 1'h1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'h1;
		rchk("ctrl reset", sms_pkg::REG_CTRL, 8'h14);
		rchk("stat reset", sms_pkg::REG_STAT, 8'h00);
		sfr_w(2'h3, 8'hFF);
		rchk("unmapped", 2'h3, 8'h00);
		rchk("ctrl kept", sms_pkg::REG_CTRL, 8'h14);
		chk("sck disabled", link.sck, 1'h1);
		// every rate code, polarity and phase taken from its low two bits, collision at code 6
		for (int k = 0; k < 8; k++) begin
			dtx = 8'h96 + k[7:0];
			ptx = 8'h3C + k[7:0];
			dv = (k == 7) ? 1 : 2 << k;
			ctl = {k[2], 3'h7, k[1], k[0], k[1], k[0]};
			axi_w(sms_pkg::PTN_CFG, {30'h0, k[1], k[0]});
			axi_w(sms_pkg::PTN_TX, {24'h0, ptx});
			sfr_w(sms_pkg::REG_CTRL, ctl);
			link.ss_n <= 1'h0;
			repeat (2) @(posedge aclk);
			n_sck = 0;
			sfr_w(sms_pkg::REG_DATA, dtx);
			t0 = cyc;
			if (k == 6) sfr_w(sms_pkg::REG_DATA, 8'hFF);
			while (irq !== 1'h1) @(posedge aclk);
			chk("byte time", (cyc - t0 >= 8 * dv - 2) && (cyc - t0 <= 8 * dv + 3), 1'h1);
			chk("sck edges", n_sck, (k == 7) ? 0 : 16);
			chk("sck idle", link.sck, k[1]);
			link.ss_n <= 1'h1;
			rchk("stat done", sms_pkg::REG_STAT, (k == 6) ? 8'hC0 : 8'h80);
			sfr_r(sms_pkg::REG_DATA, d8);
			if (k > 0 && k < 7)
				chk("rx byte", d8, ptx);
			if (k < 7) begin
				axi_r(sms_pkg::PTN_RX, r);
				chk("ptn rx", r[8:0], {1'h1, dtx});
			end
			rchk("stat clear", sms_pkg::REG_STAT, (k == 6) ? 8'h40 : 8'h00);
			chk("irq clear", irq, 1'h0);
		end
		// another master pulls select low while this end is master
		sfr_w(sms_pkg::REG_CTRL, 8'h54);
		link.ss_n <= 1'h0;
		repeat (3) @(posedge aclk);
		chk("mode_fault_flag irq", irq, 1'h1);
		serial_irq_enable <= 1'h0;
		@(posedge aclk);
		chk("irq masked", irq, 1'h0);
		serial_irq_enable <= 1'h1;
		global_irq_enable <= 1'h0;
		@(posedge aclk);
		chk("irq global", irq, 1'h0);
		global_irq_enable <= 1'h1;
		link.ss_n <= 1'h1;
		rchk("ctrl fault", sms_pkg::REG_CTRL, 8'h04);
		chk("sck off", link.sck, 1'h1);
		sfr_w(sms_pkg::REG_CTRL, 8'h04);
		rchk("mode_fault_flag kept", sms_pkg::REG_STAT, 8'h10);
		sfr_w(sms_pkg::REG_CTRL, 8'h04);
		rchk("mode_fault_flag clear", sms_pkg::REG_STAT, 8'h00);
		// slave end drives its output only when loaded and selected
		sfr_w(sms_pkg::REG_CTRL, 8'h40);
		link.ss_n <= 1'h0;
		repeat (2) @(posedge aclk);
		chk("slave unloaded", link.dev_miso_oe_n, 1'h1);
		link.ss_n <= 1'h1;
		sfr_w(sms_pkg::REG_DATA, 8'h5A);
		sfr_w(sms_pkg::REG_CTRL, 8'h60);
		repeat (2) @(posedge aclk);
		chk("select_input_disable phase0", link.dev_miso_oe_n, 1'h1);
		link.ss_n <= 1'h0;
		repeat (2) @(posedge aclk);
		chk("slave msb oe", link.dev_miso_oe_n, 1'h0);
		chk("slave msb", link.dev_miso_o, 1'h0);
		link.ss_n <= 1'h1;
		stop_test();
	end
endmodule : sms_ctrl_tb
`default_nettype wire
